// file: rtl/period_table.sv
/*
 * Period lookup: maps the captured frequency strap code to an oscillator
 * period in system clock cycles, read data registered.
 * Assumes the strap code is stable after capture.
 */
module period_table #(
    parameter int CNT_W = 16,
    parameter int STRAP_W = 3
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [STRAP_W-1:0] code_in,
    output logic [CNT_W-1:0] period_out
);
    // -----------------------------------------------------------------
    // table of periods (default steps: 250k .. 2M, plain values)
    // -----------------------------------------------------------------
    localparam logic [CNT_W-1:0] PERIODS [8] = '{
        16'h00A0, 16'h0050, 16'h0035, 16'h0028,
        16'h0020, 16'h001B, 16'h0017, 16'h0014
    };

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            period_out <= PERIODS[0];
        end else begin
            period_out <= PERIODS[code_in];
        end
    end
endmodule

// file: rtl/sync_ctrl_pkg.sv
/*
 * Package for the synchronization controller: timing constants, field
 * widths, mode states and the strap-capture struct.
 * Assumes a 40 MHz system clock (25 ns period).
 */
package sync_ctrl_pkg;
    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 25000;
    localparam int SLAVE_FREQ_KHZ = 250;
    localparam int DETECT_FREQ_KHZ = 275;
    localparam int MIN_ON_TIME_NS = 340;
    // longest period still counted as fast: rounds down
    localparam int DETECT_PERIOD_CYC = 1000000000 / (DETECT_FREQ_KHZ * CLK_PERIOD_PS);
    localparam int SLAVE_PERIOD_CYC = 1000000000 / (SLAVE_FREQ_KHZ * CLK_PERIOD_PS);
    // pulse width driven on the line: least time, rounds up
    localparam int PULSE_CYC = (MIN_ON_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ENTRY_PULSES = 10;
    localparam int CNT_W = 16;
    localparam int STRAP_W = 3;

    // -----------------------------------------------------------------
    // types
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_STRAP = 2'b00,
        ST_LEADER = 2'b01,
        ST_FOLLOWER = 2'b10,
        ST_RETURN = 2'b11
    } mode_type;

    typedef struct packed {
        logic [STRAP_W-1:0] freq_select_strap;
        logic latched_follower;
    } strap_type;
endpackage

// file: rtl/sync_master_slave_ctrl.sv
/*
 * Leader/follower synchronization controller for a switching regulator.
 * Drives or follows the shared sync line, produces the switching start
 * pulse and the slope compensation code.
 * Assumes RST_N_IN is asserted on power-up and undervoltage lockout,
 * and that the sync line is an open-drain wire with pull-up.
 */
//
// Contract
// - the sync line is two-way: driven as leader, observed as follower.
// - linked to a leader, the follower switches half a period after its line pulse.
// - on an external reference the switching starts in phase with the pulse.
// - after reset the device leads at its strapped frequency.
// - as follower the oscillator runs at 250 kHz and drives the line at that rate; the code drives it only while no line pulses arrive.
// - ten consecutive line periods faster than 275 kHz enter follower mode.
// - follower holds while pulses are fast, else leads after one 250 kHz pulse.
// - a line held low at power-up latches follower mode until the next reset.
// - slope compensation comes from the strap once at power-up and then holds.
// - the strap is sampled once at power-up then its pin is released.
module sync_master_slave_ctrl #(
    parameter int CNT_W = sync_ctrl_pkg::CNT_W,
    parameter int STRAP_W = sync_ctrl_pkg::STRAP_W,
    parameter logic [1:0] PHASE_MODE = 2'h0
) (
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic SYNC_LINE_IN,
    output logic SYNC_LINE_OUT,
    output logic SYNC_LINE_OE_N_OUT,
    input wire logic [STRAP_W-1:0] FREQ_SELECT_STRAP_IN,
    output logic FREQ_SELECT_STRAP_OE_N_OUT,
    output logic SWITCH_START_OUT,
    output logic FOLLOWER_OUT,
    output logic [STRAP_W-1:0] SLOPE_COMP_OUT
);
    localparam logic [CNT_W-1:0] DETECT_CYC = CNT_W'(sync_ctrl_pkg::DETECT_PERIOD_CYC);
    localparam logic [CNT_W-1:0] SLAVE_CYC = CNT_W'(sync_ctrl_pkg::SLAVE_PERIOD_CYC);
    localparam logic [CNT_W-1:0] PULSE_W = CNT_W'(sync_ctrl_pkg::PULSE_CYC);
    localparam logic [3:0] ENTRY = 4'(sync_ctrl_pkg::ENTRY_PULSES);

    // -----------------------------------------------------------------
    // input synchronisers
    // -----------------------------------------------------------------
    logic line_meta;
    logic line_sync;
    logic line_prev;
    logic [STRAP_W-1:0] strap_meta;
    logic [STRAP_W-1:0] strap_sync;

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            line_meta <= 1'b1;
            line_sync <= 1'b1;
            line_prev <= 1'b1;
            strap_meta <= '0;
            strap_sync <= '0;
        end else begin
            line_meta <= SYNC_LINE_IN;
            line_sync <= line_meta;
            line_prev <= line_sync;
            strap_meta <= FREQ_SELECT_STRAP_IN;
            strap_sync <= strap_meta;
        end
    end

    // line pulses are active high; rising edge marks a period start
    wire line_rise = line_sync && !line_prev;

    // -----------------------------------------------------------------
    // strap capture at power-up
    // -----------------------------------------------------------------
    sync_ctrl_pkg::mode_type mode;
    sync_ctrl_pkg::strap_type strap;
    logic [1:0] settle;

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            strap <= '0;
            settle <= 2'h0;
        end else if (mode == sync_ctrl_pkg::ST_STRAP) begin
            settle <= settle + 2'h1;
            if (settle == 2'h3) begin
                strap.freq_select_strap <= strap_sync;
                strap.latched_follower <= !line_sync;
            end
        end
    end

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            FREQ_SELECT_STRAP_OE_N_OUT <= 1'b1;
            SLOPE_COMP_OUT <= '0;
        end else begin
            // strap pin is never driven: it floats once sampled
            FREQ_SELECT_STRAP_OE_N_OUT <= 1'b1;
            SLOPE_COMP_OUT <= strap.freq_select_strap;
        end
    end

    logic [CNT_W-1:0] strap_period;

    period_table #(
        .CNT_W(CNT_W),
        .STRAP_W(STRAP_W)
    ) u_table (
        .clk_in(MCLK_IN),
        .rst_n_in(RST_N_IN),
        .code_in(strap.freq_select_strap),
        .period_out(strap_period)
    );

    // -----------------------------------------------------------------
    // line period measurement and fast-pulse count
    // -----------------------------------------------------------------
    logic [CNT_W-1:0] meas;
    logic [3:0] fast_cnt;
    logic own_drive;
    wire ext_rise = line_rise && !own_drive;
    wire fast = ext_rise && (meas <= DETECT_CYC);

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            meas <= '0;
            fast_cnt <= 4'h0;
        end else begin
            if (ext_rise) begin
                meas <= '0;
                if (!fast) begin
                    fast_cnt <= 4'h0;
                end else if (fast_cnt != ENTRY) begin
                    fast_cnt <= fast_cnt + 4'h1;
                end
            end else if (meas != '1) begin
                meas <= meas + 1'b1;
                if (meas > DETECT_CYC) begin
                    fast_cnt <= 4'h0;
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // mode control
    // -----------------------------------------------------------------
    logic [CNT_W-1:0] osc;
    wire [CNT_W-1:0] period = (mode == sync_ctrl_pkg::ST_LEADER) ? strap_period : SLAVE_CYC;
    wire osc_wrap = (osc >= period - 1'b1);

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            mode <= sync_ctrl_pkg::ST_STRAP;
        end else begin
            unique case (mode)
                sync_ctrl_pkg::ST_STRAP: begin
                    if (settle == 2'h3) begin
                        mode <= !line_sync ? sync_ctrl_pkg::ST_FOLLOWER
                                           : sync_ctrl_pkg::ST_LEADER;
                    end
                end
                sync_ctrl_pkg::ST_LEADER: begin
                    if (fast && fast_cnt == ENTRY - 4'h1) begin
                        mode <= sync_ctrl_pkg::ST_FOLLOWER;
                    end
                end
                sync_ctrl_pkg::ST_FOLLOWER: begin
                    // pulses stopped or slowed: drive one own pulse first
                    if (!strap.latched_follower && meas > DETECT_CYC) begin
                        mode <= sync_ctrl_pkg::ST_RETURN;
                    end
                end
                sync_ctrl_pkg::ST_RETURN: begin
                    if (ext_rise) begin
                        mode <= sync_ctrl_pkg::ST_FOLLOWER;
                    end else if (own_drive && osc == PULSE_W - 1'b1) begin
                        mode <= sync_ctrl_pkg::ST_LEADER;
                    end
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // oscillator, line drive and switching start
    // -----------------------------------------------------------------
    logic [CNT_W-1:0] half_cnt;
    logic half_armed;

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            osc <= '0;
            own_drive <= 1'b0;
            SYNC_LINE_OUT <= 1'b0;
            SYNC_LINE_OE_N_OUT <= 1'b1;
            SWITCH_START_OUT <= 1'b0;
            FOLLOWER_OUT <= 1'b0;
            half_cnt <= '0;
            half_armed <= 1'b0;
        end else begin
            SWITCH_START_OUT <= 1'b0;
            FOLLOWER_OUT <= (mode == sync_ctrl_pkg::ST_FOLLOWER);
            if (mode == sync_ctrl_pkg::ST_FOLLOWER && ext_rise) begin
                // follower locks its oscillator to each line pulse
                osc <= '0;
                if (PHASE_MODE == 2'h0) begin
                    SWITCH_START_OUT <= 1'b1;
                end else begin
                    // half of the line period just measured
                    half_cnt <= meas >> 1;
                    half_armed <= 1'b1;
                end
            end else if (mode != sync_ctrl_pkg::ST_STRAP) begin
                osc <= osc_wrap ? '0 : osc + 1'b1;
                // a follower without line pulses runs free at its own rate
                if (osc_wrap) begin
                    SWITCH_START_OUT <= 1'b1;
                end
            end
            if (half_armed) begin
                half_cnt <= half_cnt - 1'b1;
                if (half_cnt == '0) begin
                    half_armed <= 1'b0;
                    SWITCH_START_OUT <= 1'b1;
                end
            end
            // drive a high pulse on the line at every oscillator wrap
            if (osc_wrap && mode != sync_ctrl_pkg::ST_STRAP) begin
                own_drive <= 1'b1;
            end else if (osc == PULSE_W - 1'b1) begin
                own_drive <= 1'b0;
            end
            SYNC_LINE_OUT <= own_drive;
            SYNC_LINE_OE_N_OUT <= !own_drive;
        end
    end
endmodule

// file: tb/sync_ctrl_assertions.sv
/*
 * Port checker for the sync controller, bound to every instance.
 * Assumes the strap code is held steady from power-up on.
 */
module sync_ctrl_assertions #(
    parameter int STRAP_W = 3
) (
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic SYNC_LINE_IN,
    input wire logic SYNC_LINE_OUT,
    input wire logic SYNC_LINE_OE_N_OUT,
    input wire logic FREQ_SELECT_STRAP_OE_N_OUT,
    input wire logic SWITCH_START_OUT,
    input wire logic FOLLOWER_OUT,
    input wire logic [STRAP_W-1:0] SLOPE_COMP_OUT
);
    // ---------------------------------------------------------------
    // helper counters
    // ---------------------------------------------------------------
    localparam logic [7:0] PER [8] = '{8'hA0, 8'h50, 8'h35, 8'h28, 8'h20, 8'h1B, 8'h17, 8'h14};
    logic [3:0] since;
    logic [7:0] gap;
    logic [7:0] low_run;
    logic [1:0] lead_n;
    logic low_boot;
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) since <= 4'h0;
        else if (since != 4'hF) since <= since + 4'h1;
    end
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) low_boot <= 1'b1;
        else if (since < 4'h8 && SYNC_LINE_IN) low_boot <= 1'b0;
    end
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) gap <= 8'h00;
        else if (SWITCH_START_OUT) gap <= 8'h01;
        else if (gap != 8'hFF) gap <= gap + 8'h01;
    end
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) lead_n <= 2'h0;
        else if (FOLLOWER_OUT) lead_n <= 2'h0;
        else if (SWITCH_START_OUT && lead_n != 2'h3) lead_n <= lead_n + 2'h1;
    end
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) low_run <= 8'h00;
        else if (SYNC_LINE_OE_N_OUT) low_run <= 8'h00;
        else if (low_run != 8'hFF) low_run <= low_run + 8'h01;
    end
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);
    sequence lead_start;
        SWITCH_START_OUT && !FOLLOWER_OUT;
    endsequence
    sequence own_pulse;
        !SYNC_LINE_OE_N_OUT && SYNC_LINE_OUT;
    endsequence
    chk_drive_after: assert property (lead_start |=> own_pulse)
        else $error("leader start not followed by line drive");
    chk_drive_high: assert property (!SYNC_LINE_OE_N_OUT |-> SYNC_LINE_OUT)
        else $error("line driven without pulse level");
    chk_pulse_width: assert property ($rose(SYNC_LINE_OE_N_OUT) |->
        low_run == sync_ctrl_pkg::PULSE_CYC) else $error("own pulse width wrong");
    chk_start_single: assert property (SWITCH_START_OUT |=> !SWITCH_START_OUT)
        else $error("switch start longer than one cycle");
    chk_lead_period: assert property (lead_start and lead_n == 2'h3 |->
        gap == PER[SLOPE_COMP_OUT]) else $error("leader period wrong");
    chk_reset_idle: assert property ($rose(RST_N_IN) |-> !FOLLOWER_OUT
        && SYNC_LINE_OE_N_OUT && !SWITCH_START_OUT) else $error("outputs not idle");
    chk_slope_hold: assert property (since > 4'h8 |-> $stable(SLOPE_COMP_OUT))
        else $error("slope code changed");
    chk_strap_float: assert property (since > 4'h0 |-> FREQ_SELECT_STRAP_OE_N_OUT)
        else $error("strap pin driven");
    chk_latch_hold: assert property (since == 4'hF && low_boot |-> FOLLOWER_OUT)
        else $error("latched follower lost");
endmodule

bind sync_master_slave_ctrl sync_ctrl_assertions #(.STRAP_W(STRAP_W)) sync_ctrl_assertions_inst (
    .MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN), .SYNC_LINE_IN(SYNC_LINE_IN),
    .SYNC_LINE_OUT(SYNC_LINE_OUT), .SYNC_LINE_OE_N_OUT(SYNC_LINE_OE_N_OUT),
    .FREQ_SELECT_STRAP_OE_N_OUT(FREQ_SELECT_STRAP_OE_N_OUT),
    .SWITCH_START_OUT(SWITCH_START_OUT), .FOLLOWER_OUT(FOLLOWER_OUT),
    .SLOPE_COMP_OUT(SLOPE_COMP_OUT));

// file: tb/sync_partner.sv
/*
 * External sync source: pulses of two link ticks, period in ticks.
 * Assumes a pull-up on the line when released.
 */
module sync_partner (
    input wire logic link_clk_in,
    input wire logic run_in,
    input wire logic hold_low_in,
    input wire logic [7:0] ticks_in,
    output logic line_out,
    output logic line_oe_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] tick = 8'h00;
    logic [7:0] span = 8'h0A;
    // new period length takes effect at the next wrap only
    always @(posedge link_clk_in) begin
        if (!run_in) tick <= 8'h00;
        else if (tick + 8'h01 >= span) begin
            tick <= 8'h00;
            span <= ticks_in;
        end else tick <= tick + 8'h01;
    end
    assign line_out = run_in && tick != 8'h00 && tick < 8'h03;
    assign line_oe_n_out = !(run_in || hold_low_in);
endmodule

// file: tb/test_sync_master_slave_ctrl.sv
/*
 * Bench: leader, follower entry and exit, latched follower.
 * Assumes sync_ctrl_pkg, the bound checker and the partner model.
 */
module test_sync_master_slave_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst_n, run, hold, link_clk, p_line, p_oe_n, line;
    logic sl_out, sl_oe_n, strap_oe_n, start, follower, start_b;
    logic [2:0] strap, slope;
    logic [7:0] ticks;
    int miscompares, checked, cycles, n;
    // open-drain line with pull-up: any low driver wins
    assign line = !((!sl_oe_n && !sl_out) || (!p_oe_n && !p_line));
    always #12.5 mclk = !mclk;
    initial begin
        link_clk = 1'b0;
        #37;
        forever #100 link_clk = !link_clk;
    end
    sync_master_slave_ctrl sync_master_slave_ctrl_inst (.MCLK_IN(mclk), .RST_N_IN(rst_n),
        .SYNC_LINE_IN(line), .SYNC_LINE_OUT(sl_out), .SYNC_LINE_OE_N_OUT(sl_oe_n),
        .FREQ_SELECT_STRAP_IN(strap), .FREQ_SELECT_STRAP_OE_N_OUT(strap_oe_n),
        .SWITCH_START_OUT(start), .FOLLOWER_OUT(follower), .SLOPE_COMP_OUT(slope));
    sync_partner sync_partner_inst (.link_clk_in(link_clk), .run_in(run),
        .hold_low_in(hold), .ticks_in(ticks), .line_out(p_line), .line_oe_n_out(p_oe_n));
    // second device on the line, following with the half-period offset
    sync_master_slave_ctrl #(.PHASE_MODE(2'h1)) half_sync_master_slave_ctrl_inst (
        .MCLK_IN(mclk), .RST_N_IN(rst_n), .SYNC_LINE_IN(line), .SYNC_LINE_OUT(),
        .SYNC_LINE_OE_N_OUT(), .FREQ_SELECT_STRAP_IN(strap), .FREQ_SELECT_STRAP_OE_N_OUT(),
        .SWITCH_START_OUT(start_b), .FOLLOWER_OUT(), .SLOPE_COMP_OUT());
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task tally_and_finish;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // cycles between two rising events of start or of own drive
    task automatic span_of(input bit drv, output int cnt);
        logic prev, cur;
        int k;
        cnt = 0;
        k = 0;
        prev = 1'b1;
        while (k < 2 && cnt < 2000) begin
            @(negedge mclk);
            cur = drv ? !sl_oe_n : start;
            if (cur && !prev) k++;
            if (k == 1) cnt++;
            prev = cur;
        end
    endtask
    task do_reset(input logic low);
        @(negedge mclk);
        rst_n = 1'b0;
        hold = low;
        repeat (16) @(negedge mclk);
        rst_n = 1'b1;
        repeat (20) @(negedge mclk);
        hold = 1'b0;
        check(16'(follower), 16'(low));
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task t_leader;
        do_reset(1'b0);
        check(16'(slope), 16'h0001);
        check(16'(strap_oe_n), 16'h0001);
        strap = 3'h5;
        span_of(1'b0, n);
        check(16'(n), 16'h0050);
        check(16'(slope), 16'h0001);
        strap = 3'h1;
    endtask
    task automatic t_follow;
        int i;
        span_of(1'b1, n);
        check(16'(n), 16'h0050);
        repeat (16) @(negedge mclk);
        ticks = 8'h0A;
        run = 1'b1;
        repeat (8) @(posedge p_line);
        ticks = 8'h14;
        repeat (2) @(posedge p_line);
        ticks = 8'h0A;
        repeat (8) @(posedge p_line);
        check(16'(follower), 16'h0000);
        repeat (5) @(posedge p_line);
        check(16'(follower), 16'h0001);
        @(posedge p_line);
        for (i = 0; i < 12 && start !== 1'b1; i++) @(negedge mclk);
        check(16'(start), 16'h0001);
        // 80-cycle line period: the offset device starts 40 cycles later
        for (i = 0; i < 200 && start_b !== 1'b1; i++) @(negedge mclk);
        check(16'(i), 16'h0028);
        span_of(1'b0, n);
        check(16'(n), 16'h0050);
        repeat (10) @(posedge p_line);
        check(16'(follower), 16'h0001);
        @(negedge mclk);
        run = 1'b0;
        // last locked start to the lone own pulse: one 250 kHz period
        span_of(1'b0, n);
        check(16'(n), 16'h00A0);
        for (i = 0; i < 1000 && follower !== 1'b0; i++) @(negedge mclk);
        check(16'(follower), 16'h0000);
        span_of(1'b0, n);
        span_of(1'b0, n);
        check(16'(n), 16'h0050);
    endtask
    task t_latch;
        do_reset(1'b1);
        span_of(1'b1, n);
        check(16'(n), 16'h00A0);
        repeat (400) @(negedge mclk);
        check(16'(follower), 16'h0001);
        do_reset(1'b0);
    endtask
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        run = 1'b0;
        hold = 1'b0;
        ticks = 8'h0A;
        strap = 3'h1;
        t_leader();
        t_follow();
        t_latch();
        tally_and_finish();
    end
endmodule
